// ==== shared/bdf_pkg.sv ====
// constants and types shared by the bidirectional fifo port control
package bdf_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANE_DATA_W = 8;
  localparam int LANES = 4;
  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W = 7;
  localparam int OFFSET_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;
  // almost-flag offsets selected by {offset_sel_hi, offset_sel_lo}
  localparam logic [OFFSET_W-1:0] OFFSET_HH = 5'h10;
  localparam logic [OFFSET_W-1:0] OFFSET_HL = 5'h0C;
  localparam logic [OFFSET_W-1:0] OFFSET_LH = 5'h08;
  localparam logic [OFFSET_W-1:0] OFFSET_LL = 5'h04;
  // lane index xor key per swap mode
  localparam logic [1:0] SWAP_KEY_NONE = 2'h0;
  localparam logic [1:0] SWAP_KEY_BYTE = 2'h3;
  localparam logic [1:0] SWAP_KEY_WORD = 2'h2;
  localparam logic [1:0] SWAP_KEY_BYTE_WORD = 2'h1;
  // flag vector bit positions, all flags active low
  localparam int FLG_EMPTY = 0;
  localparam int FLG_AEMPTY = 1;
  localparam int FLG_AFULL = 2;
  localparam int FLG_FULL = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h4;
  typedef enum logic [1:0] {BDF_SWAP_NONE, BDF_SWAP_BYTE, BDF_SWAP_WORD, BDF_SWAP_BYTE_WORD} bdf_swap_e;
  typedef enum logic [1:0] {BDF_SIZE_LONG, BDF_SIZE_WORD, BDF_SIZE_BYTE, BDF_SIZE_MAIL} bdf_size_e;
endpackage : bdf_pkg

// ==== verilog/bdf_fifo.sv ====
// flip-flop fifo with valid/ready on both sides and a fill count
`timescale 1ns/1ps
module bdf_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule : bdf_fifo

// ==== verilog/bdf_port_ctrl.sv ====
// bidirectional two-fifo port control with mailboxes, swap and parity generation
// Functional notes
// [RULE_01] port-B read parity replaces top bit of each 9-bit lane, odd/even chosen
// [RULE_02] reset must be held low for four clock edges on each port
// [RULE_03] reset drives almost-full and mail flags high, others low
// [RULE_04] reset returns both fifo pointers to start
// [RULE_05] reset arrives asynchronously and is synchronised before release
// [RULE_06] full flags rise on second clock edge after reset release
// [RULE_07] outside party resets device before writing any fifo data
// [RULE_08] almost-flag offset latched from two selects at reset release: 16/12/8/4
// [RULE_09] port-B size and endian sampled one edge, applied the next
// [RULE_10] both size selects high routes port B to the mailboxes, full width
// [RULE_11] swap selects sampled at start of each port-B long-word transfer
// [RULE_12] port-A bus driven only while chip select and write/read low
// [RULE_13] port-A enabled write with mailbox low and not full loads fifo A-to-B
// [RULE_14] port-A enabled read with mailbox low and not empty pops fifo B-to-A
// [RULE_15] port-A mailbox write loads A-to-B mail; read outputs B-to-A, sets flag
// [RULE_16] port-A read without enable keeps driving the selected source
// [RULE_17] port-B enabled write, not full, not mailbox size loads fifo B-to-A
// [RULE_18] port-B bus driven only while chip select and write/read low
// [RULE_19] port-B write/read high means write, low means read
// [RULE_20] selects may change freely in cycles where enable is low
// [RULE_21] port-B enabled read, not empty, not mailbox size pops fifo A-to-B
// [RULE_22] mailbox write drops its flag; further writes blocked until far read
// [RULE_23] swap codes: 00 none, 01 byte, 10 word, 11 byte-word
// [RULE_24] size codes: 00 long, 01 word, 10 byte, 11 mailbox
// [RULE_25] reset release synchronised into the clock domain for clean start
`timescale 1ns/1ps
module bdf_port_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic offset_sel_lo,
  input wire logic offset_sel_hi,
  input wire logic odd_even_sel,
  input wire logic porta_chip_sel_n,
  input wire logic porta_write_read_sel,
  input wire logic porta_enable,
  input wire logic porta_mailbox_sel,
  input wire logic porta_parity_gen_en,
  input wire logic [35:0] porta_data_in,
  output logic [35:0] porta_data_out,
  output logic porta_data_oe,
  output logic porta_full_n,
  output logic porta_empty_n,
  output logic porta_almost_full_n,
  output logic porta_almost_empty_n,
  input wire logic portb_chip_sel_n,
  input wire logic portb_write_read_sel,
  input wire logic portb_enable,
  input wire logic portb_size_sel_lo,
  input wire logic portb_size_sel_hi,
  input wire logic portb_endian_sel,
  input wire logic portb_swap_sel_lo,
  input wire logic portb_swap_sel_hi,
  input wire logic portb_parity_gen_en,
  input wire logic [35:0] portb_data_in,
  output logic [35:0] portb_data_out,
  output logic portb_data_oe,
  output logic portb_full_n,
  output logic portb_empty_n,
  output logic portb_almost_full_n,
  output logic portb_almost_empty_n,
  output logic [2:0] portb_size_applied,
  output logic a_to_b_mail_flag_n,
  output logic b_to_a_mail_flag_n
);
  localparam int DW = bdf_pkg::DATA_W;
  localparam int CW = bdf_pkg::CNT_W;

  logic rel_meta;
  logic run;
  logic [bdf_pkg::OFFSET_W-1:0] offset;
  logic [2:0] size_smp;
  bdf_pkg::bdf_size_e size_app;
  bdf_pkg::bdf_swap_e swap_rd;
  bdf_pkg::bdf_swap_e swap_now;
  logic [DW-1:0] mail_a2b;
  logic [DW-1:0] mail_b2a;
  logic [DW-1:0] a_fifo_out;
  logic [DW-1:0] b_fifo_out;
  logic ab_in_ready, ab_out_valid, ba_in_ready, ba_out_valid;
  logic [DW-1:0] ab_out_data;
  logic [DW-1:0] ba_out_data;
  logic [CW-1:0] ab_count;
  logic [CW-1:0] ba_count;
  logic a_wr, a_rd, b_wr, b_rd, b_mail;
  logic a_fifo_wr, a_mail_wr, a_fifo_rd, a_mail_rd;
  logic b_fifo_wr, b_mail_wr, b_fifo_rd, b_mail_rd;
  logic [3:0] ab_flags;
  logic [3:0] ba_flags;
  logic [DW-1:0] next_porta_data;
  logic [DW-1:0] next_portb_data;

  function automatic bdf_pkg::bdf_swap_e swap_decode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: swap_decode = bdf_pkg::BDF_SWAP_NONE;
      2'h1: swap_decode = bdf_pkg::BDF_SWAP_BYTE;
      2'h2: swap_decode = bdf_pkg::BDF_SWAP_WORD;
      default: swap_decode = bdf_pkg::BDF_SWAP_BYTE_WORD;
    endcase
  endfunction : swap_decode

  function automatic bdf_pkg::bdf_size_e size_decode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: size_decode = bdf_pkg::BDF_SIZE_LONG;
      2'h1: size_decode = bdf_pkg::BDF_SIZE_WORD;
      2'h2: size_decode = bdf_pkg::BDF_SIZE_BYTE;
      default: size_decode = bdf_pkg::BDF_SIZE_MAIL;
    endcase
  endfunction : size_decode

  function automatic logic [bdf_pkg::OFFSET_W-1:0] offset_decode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h3: offset_decode = bdf_pkg::OFFSET_HH;
      2'h2: offset_decode = bdf_pkg::OFFSET_HL;
      2'h1: offset_decode = bdf_pkg::OFFSET_LH;
      default: offset_decode = bdf_pkg::OFFSET_LL;
    endcase
  endfunction : offset_decode

  // lane i of the result takes lane (i xor key)
  function automatic logic [DW-1:0] swap_lanes(input logic [DW-1:0] d, input bdf_pkg::bdf_swap_e m);
    logic [1:0] key;
    key = bdf_pkg::SWAP_KEY_NONE;
    case (m)
      bdf_pkg::BDF_SWAP_BYTE: key = bdf_pkg::SWAP_KEY_BYTE;
      bdf_pkg::BDF_SWAP_WORD: key = bdf_pkg::SWAP_KEY_WORD;
      bdf_pkg::BDF_SWAP_BYTE_WORD: key = bdf_pkg::SWAP_KEY_BYTE_WORD;
      default: key = bdf_pkg::SWAP_KEY_NONE;
    endcase
    for (int i = 0; i < bdf_pkg::LANES; i++) begin
      swap_lanes[i*bdf_pkg::LANE_W +: bdf_pkg::LANE_W] =
        d[(2'(i) ^ key)*bdf_pkg::LANE_W +: bdf_pkg::LANE_W];
    end
  endfunction : swap_lanes

  function automatic logic [DW-1:0] parity_fill(input logic [DW-1:0] d, input logic odd);
    parity_fill = d;
    for (int i = 0; i < bdf_pkg::LANES; i++) begin
      parity_fill[i*bdf_pkg::LANE_W + bdf_pkg::LANE_DATA_W] =
        odd ^ (^d[i*bdf_pkg::LANE_W +: bdf_pkg::LANE_DATA_W]);
    end
  endfunction : parity_fill

  // {full_n, almost_full_n, almost_empty_n, empty_n} for a fill level
  function automatic logic [3:0] level_flags(input logic [CW-1:0] cnt,
                                             input logic [bdf_pkg::OFFSET_W-1:0] x);
    level_flags[bdf_pkg::FLG_EMPTY] = (cnt != '0);
    level_flags[bdf_pkg::FLG_AEMPTY] = (cnt > CW'(x));
    level_flags[bdf_pkg::FLG_AFULL] = (cnt < (bdf_pkg::FIFO_FULL_CNT - CW'(x)));
    level_flags[bdf_pkg::FLG_FULL] = (cnt != bdf_pkg::FIFO_FULL_CNT);
  endfunction : level_flags

  // reset release synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rel_meta <= 1'h0;
      run <= 1'h0;
    end else begin
      rel_meta <= 1'h1; // RULE_05
      run <= rel_meta; // RULE_25
    end
  end

  // offset follows the selects until the synchronised release freezes it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      offset <= bdf_pkg::OFFSET_LL;
    end else if (!run) begin
      offset <= offset_decode(offset_sel_hi, offset_sel_lo); // RULE_08
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      size_smp <= 3'h0;
      size_app <= bdf_pkg::BDF_SIZE_LONG;
      portb_size_applied <= 3'h0;
    end else begin
      size_smp <= {portb_endian_sel, portb_size_sel_hi, portb_size_sel_lo}; // RULE_09
      size_app <= size_decode(size_smp[1], size_smp[0]); // RULE_24
      portb_size_applied <= size_smp;
    end
  end

  assign a_wr = run & ~porta_chip_sel_n & porta_enable & porta_write_read_sel;
  assign a_rd = run & ~porta_chip_sel_n & porta_enable & ~porta_write_read_sel;
  assign b_wr = run & ~portb_chip_sel_n & portb_enable & portb_write_read_sel; // RULE_19
  assign b_rd = run & ~portb_chip_sel_n & portb_enable & ~portb_write_read_sel; // RULE_19
  assign b_mail = (size_app == bdf_pkg::BDF_SIZE_MAIL); // RULE_10
  assign a_fifo_wr = a_wr & ~porta_mailbox_sel & porta_full_n & ab_in_ready; // RULE_13
  assign a_mail_wr = a_wr & porta_mailbox_sel & a_to_b_mail_flag_n; // RULE_22
  assign a_fifo_rd = a_rd & ~porta_mailbox_sel & porta_empty_n & ba_out_valid; // RULE_14
  assign a_mail_rd = a_rd & porta_mailbox_sel; // RULE_15
  assign b_fifo_wr = b_wr & ~b_mail & portb_full_n & ba_in_ready; // RULE_17
  assign b_mail_wr = b_wr & b_mail & b_to_a_mail_flag_n; // RULE_22
  assign b_fifo_rd = b_rd & ~b_mail & portb_empty_n & ab_out_valid; // RULE_21
  assign b_mail_rd = b_rd & b_mail; // RULE_10

  bdf_fifo #(.WIDTH(DW), .DEPTH(bdf_pkg::FIFO_DEPTH)) a_to_b_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clear(~run), // RULE_04
    .in_valid(a_fifo_wr),
    .in_ready(ab_in_ready),
    .in_data(porta_data_in),
    .out_valid(ab_out_valid),
    .out_ready(b_fifo_rd),
    .out_data(ab_out_data),
    .count(ab_count)
  );

  bdf_fifo #(.WIDTH(DW), .DEPTH(bdf_pkg::FIFO_DEPTH)) b_to_a_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clear(~run), // RULE_04
    .in_valid(b_fifo_wr),
    .in_ready(ba_in_ready),
    .in_data(swap_lanes(portb_data_in, swap_decode(portb_swap_sel_hi, portb_swap_sel_lo))),
    .out_valid(ba_out_valid),
    .out_ready(a_fifo_rd),
    .out_data(ba_out_data),
    .count(ba_count)
  );

  assign ab_flags = level_flags(ab_count + CW'(a_fifo_wr) - CW'(b_fifo_rd), offset);
  assign ba_flags = level_flags(ba_count + CW'(b_fifo_wr) - CW'(a_fifo_rd), offset);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {porta_full_n, porta_almost_full_n, porta_almost_empty_n, porta_empty_n} <=
        bdf_pkg::FLAGS_RESET; // RULE_03
      {portb_full_n, portb_almost_full_n, portb_almost_empty_n, portb_empty_n} <=
        bdf_pkg::FLAGS_RESET; // RULE_03
    end else if (!run) begin
      // full flags come up as the release leaves the synchroniser
      porta_full_n <= rel_meta; // RULE_06
      portb_full_n <= rel_meta; // RULE_06
    end else begin
      porta_full_n <= ab_flags[bdf_pkg::FLG_FULL];
      porta_almost_full_n <= ab_flags[bdf_pkg::FLG_AFULL];
      porta_empty_n <= ba_flags[bdf_pkg::FLG_EMPTY];
      porta_almost_empty_n <= ba_flags[bdf_pkg::FLG_AEMPTY];
      portb_full_n <= ba_flags[bdf_pkg::FLG_FULL];
      portb_almost_full_n <= ba_flags[bdf_pkg::FLG_AFULL];
      portb_empty_n <= ab_flags[bdf_pkg::FLG_EMPTY];
      portb_almost_empty_n <= ab_flags[bdf_pkg::FLG_AEMPTY];
    end
  end

  // mailboxes; a write beats a same-cycle read of the far port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail_a2b <= '0;
      a_to_b_mail_flag_n <= 1'h1; // RULE_03
    end else if (a_mail_wr) begin
      mail_a2b <= porta_data_in; // RULE_15
      a_to_b_mail_flag_n <= 1'h0; // RULE_22
    end else if (b_mail_rd) begin
      a_to_b_mail_flag_n <= 1'h1; // RULE_22
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail_b2a <= '0;
      b_to_a_mail_flag_n <= 1'h1; // RULE_03
    end else if (b_mail_wr) begin
      mail_b2a <= portb_data_in; // RULE_10
      b_to_a_mail_flag_n <= 1'h0; // RULE_22
    end else if (a_mail_rd) begin
      b_to_a_mail_flag_n <= 1'h1; // RULE_15
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_fifo_out <= '0;
      b_fifo_out <= '0;
      swap_rd <= bdf_pkg::BDF_SWAP_NONE;
    end else begin
      if (a_fifo_rd) begin
        a_fifo_out <= ba_out_data;
      end
      if (b_fifo_rd) begin
        b_fifo_out <= ab_out_data;
        swap_rd <= swap_now; // RULE_11
      end
    end
  end

  assign swap_now = b_fifo_rd ? swap_decode(portb_swap_sel_hi, portb_swap_sel_lo) : swap_rd; // RULE_23

  always_comb begin
    next_porta_data = porta_mailbox_sel ? mail_b2a : (a_fifo_rd ? ba_out_data : a_fifo_out); // RULE_16
    if (porta_parity_gen_en) begin
      next_porta_data = parity_fill(next_porta_data, odd_even_sel);
    end
    next_portb_data = b_mail ? mail_a2b :
      swap_lanes(b_fifo_rd ? ab_out_data : b_fifo_out, swap_now); // RULE_11
    if (portb_parity_gen_en) begin
      next_portb_data = parity_fill(next_portb_data, odd_even_sel); // RULE_01
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      porta_data_out <= '0;
      portb_data_out <= '0;
      porta_data_oe <= 1'h0;
      portb_data_oe <= 1'h0;
    end else begin
      porta_data_out <= next_porta_data;
      portb_data_out <= next_portb_data;
      porta_data_oe <= ~porta_chip_sel_n & ~porta_write_read_sel; // RULE_12
      portb_data_oe <= ~portb_chip_sel_n & ~portb_write_read_sel; // RULE_18
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_parity_lane_top: assert property ( // RULE_01
    portb_parity_gen_en |=> (portb_data_out[35] ==
      ($past(odd_even_sel) ^ (^portb_data_out[34:27]))))
    else $error("port-B generated parity wrong");
  a_reset_flag_levels: assert property ( // RULE_03
    !run |-> (!porta_empty_n && !portb_empty_n && !porta_almost_empty_n &&
      !portb_almost_empty_n && porta_almost_full_n && portb_almost_full_n))
    else $error("flag levels wrong during reset");
  a_full_after_release: assert property ( // RULE_06
    $rose(run) |-> (porta_full_n && portb_full_n && $past(!porta_full_n, 2)))
    else $error("full flags not raised on second edge");
  a_pointers_cleared: assert property ( // RULE_04
    !run |=> (ab_count == '0 && ba_count == '0))
    else $error("fifo not cleared by reset");
  a_offset_latched: assert property ( // RULE_08
    $rose(run) |=> (offset == offset_decode($past(offset_sel_hi, 2), $past(offset_sel_lo, 2)))
      [*3])
    else $error("offset not latched at release");
  a_size_two_edges: assert property ( // RULE_09
    run && $past(run, 2) |-> (size_app ==
      size_decode($past(portb_size_sel_hi, 2), $past(portb_size_sel_lo, 2))))
    else $error("port-B size not applied two edges later");
  a_mail_size_no_fifo: assert property ( // RULE_10
    b_mail |-> (!b_fifo_wr && !b_fifo_rd))
    else $error("fifo touched in mailbox size");
  a_porta_drive_oe: assert property ( // RULE_12
    porta_data_oe |-> $past(!porta_chip_sel_n && !porta_write_read_sel))
    else $error("port-A driven without read select");
  a_portb_drive_oe: assert property ( // RULE_18
    portb_data_oe |-> $past(!portb_chip_sel_n && !portb_write_read_sel))
    else $error("port-B driven without read select");
  a_fifo_write_count: assert property ( // RULE_13
    (a_fifo_wr && !b_fifo_rd) |=> (ab_count == $past(ab_count) + CW'(1)))
    else $error("port-A write did not add a word");
  a_portb_write_count: assert property ( // RULE_17
    (b_wr && !b_mail && portb_full_n && !a_fifo_rd) |=>
      (ba_count == $past(ba_count) + CW'(1)))
    else $error("port-B write did not add a word");
  a_mail_flag_drop: assert property ( // RULE_22
    a_mail_wr |=> (!a_to_b_mail_flag_n ##1 (a_to_b_mail_flag_n || !$past(b_mail_rd))))
    else $error("mail flag did not follow write and read");
  a_mail_read_sets: assert property ( // RULE_15
    (a_mail_rd && !b_mail_wr) |=> b_to_a_mail_flag_n)
    else $error("port-A mail read did not set flag");
  a_byte_word_swap: assert property ( // RULE_11
    (b_fifo_rd && portb_swap_sel_hi && portb_swap_sel_lo && !portb_parity_gen_en)
      |=> (portb_data_out[35:27] == $past(ab_out_data[26:18])))
    else $error("byte-word swap lane wrong");

  c_release: cover property ($rose(run));
  c_porta_fifo_write: cover property (a_fifo_wr);
  c_portb_mail_read: cover property (b_mail_rd ##1 a_mail_wr);
  c_portb_swap_read: cover property (b_fifo_rd && portb_swap_sel_lo);
endmodule : bdf_port_ctrl

// ==== tb/bdf_bus_host.sv ====
// host-side model of one port's 36-bit data bus
`timescale 1ns/1ps
module bdf_bus_host (
  input wire logic clock,
  input wire logic dev_oe,
  input wire logic [35:0] dev_data,
  input wire logic host_en,
  input wire logic [35:0] host_data,
  output logic [35:0] bus_level
);
  logic [35:0] last;
  always_ff @(posedge clock) begin
    last <= bus_level;
  end
  // a released bus shows no stale value
  always_comb begin
    if (dev_oe) begin
      bus_level = dev_data;
    end else if (host_en) begin
      bus_level = host_data;
    end else begin
      bus_level = ~last;
    end
  end
endmodule : bdf_bus_host

// ==== tb/bdf_port_ctrl_tb_top.sv ====
// self-checking bench for the bidirectional fifo port control
`timescale 1ns/1ps
module bdf_port_ctrl_tb_top;
  logic clock = 0, rst_n = 0, offset_sel_lo = 0, offset_sel_hi = 0, odd_even_sel = 0;
  logic porta_chip_sel_n = 1, porta_write_read_sel = 1, porta_enable = 0;
  logic porta_mailbox_sel = 0, porta_parity_gen_en = 0;
  logic portb_chip_sel_n = 1, portb_write_read_sel = 1, portb_enable = 0;
  logic portb_size_sel_lo = 0, portb_size_sel_hi = 0, portb_endian_sel = 0;
  logic portb_swap_sel_lo = 0, portb_swap_sel_hi = 0, portb_parity_gen_en = 0;
  logic a_host_en = 0, b_host_en = 0;
  logic [35:0] a_host = 0, b_host = 0, porta_data_in, portb_data_in;
  logic [35:0] porta_data_out, portb_data_out;
  logic porta_data_oe, porta_full_n, porta_empty_n, porta_almost_full_n, porta_almost_empty_n;
  logic portb_data_oe, portb_full_n, portb_empty_n, portb_almost_full_n, portb_almost_empty_n;
  logic [2:0] portb_size_applied;
  logic a_to_b_mail_flag_n, b_to_a_mail_flag_n;
  int error_cnt = 0;
  int checked = 0;
  always #50 clock = ~clock;
  bdf_port_ctrl bdf_port_ctrl_i (.clock, .rst_n, .offset_sel_lo, .offset_sel_hi, .odd_even_sel,
    .porta_chip_sel_n, .porta_write_read_sel, .porta_enable, .porta_mailbox_sel,
    .porta_parity_gen_en, .porta_data_in, .porta_data_out, .porta_data_oe, .porta_full_n,
    .porta_empty_n, .porta_almost_full_n, .porta_almost_empty_n, .portb_chip_sel_n,
    .portb_write_read_sel, .portb_enable, .portb_size_sel_lo, .portb_size_sel_hi,
    .portb_endian_sel, .portb_swap_sel_lo, .portb_swap_sel_hi, .portb_parity_gen_en,
    .portb_data_in, .portb_data_out, .portb_data_oe, .portb_full_n, .portb_empty_n,
    .portb_almost_full_n, .portb_almost_empty_n, .portb_size_applied, .a_to_b_mail_flag_n,
    .b_to_a_mail_flag_n);
  bdf_bus_host bdf_bus_host_a_i (.clock, .dev_oe(porta_data_oe), .dev_data(porta_data_out),
    .host_en(a_host_en), .host_data(a_host), .bus_level(porta_data_in));
  bdf_bus_host bdf_bus_host_b_i (.clock, .dev_oe(portb_data_oe), .dev_data(portb_data_out),
    .host_en(b_host_en), .host_data(b_host), .bus_level(portb_data_in));
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [35:0] swp(input logic [35:0] d, input logic [1:0] k);
    for (int i = 0; i < 4; i++) swp[9*i +: 9] = d[9*(i^k) +: 9];
  endfunction : swp
  function automatic logic [35:0] par(input logic [35:0] d, input logic odd);
    par = d;
    for (int i = 0; i < 4; i++) par[9*i+8] = odd ? ~^d[9*i +: 8] : ^d[9*i +: 8];
  endfunction : par
  // reset sequence, held for six edges
  task automatic do_reset(input logic [1:0] fs);
    @(posedge clock);
    rst_n <= 0;
    {offset_sel_hi, offset_sel_lo} <= fs;
    repeat (5) @(posedge clock);
    #1;
    chk("flags in reset", 36'h3, {porta_full_n, portb_full_n, porta_empty_n, portb_empty_n,
      porta_almost_empty_n, portb_almost_empty_n, porta_almost_full_n, portb_almost_full_n,
      a_to_b_mail_flag_n, b_to_a_mail_flag_n} ^ 36'hC);
    @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    #1;
    chk("full after edge 1", 36'h0, {porta_full_n, portb_full_n});
    @(posedge clock);
    #1;
    chk("full after edge 2", 36'h3, {porta_full_n, portb_full_n});
  endtask : do_reset
  task automatic op_a(input logic wr, input logic mb, input logic [35:0] d);
    @(posedge clock);
    porta_chip_sel_n <= 0;
    porta_write_read_sel <= wr;
    porta_mailbox_sel <= mb;
    a_host <= d;
    a_host_en <= wr;
    porta_enable <= 1;
    @(posedge clock);
    porta_enable <= 0;
    // release the bus so a following write is not overdriven
    porta_chip_sel_n <= 1;
    porta_write_read_sel <= 1;
    #1;
  endtask : op_a
  task automatic op_b(input logic wr, input logic [35:0] d);
    @(posedge clock);
    portb_chip_sel_n <= 0;
    portb_write_read_sel <= wr;
    b_host <= d;
    b_host_en <= wr;
    portb_enable <= 1;
    @(posedge clock);
    portb_enable <= 0;
    // release the bus so a following write is not overdriven
    portb_chip_sel_n <= 1;
    portb_write_read_sel <= 1;
    #1;
  endtask : op_b
  // each offset code: fill to X words, then one more
  task automatic s_offset;
    int x;
    for (int c = 3; c >= 0; c--) begin
      x = (c == 3) ? 16 : (c == 2) ? 12 : (c == 1) ? 8 : 4;
      do_reset(c[1:0]);
      chk("empty after reset", 36'h0, portb_empty_n);
      for (int n = 0; n < x; n++) op_a(1, 0, 36'hA00000000 + n);
      chk("almost empty at x", 36'h0, portb_almost_empty_n);
      op_a(1, 0, 36'hA00000000 + x);
      chk("almost empty at x+1", 36'h1, portb_almost_empty_n);
      chk("porta oe on write", 36'h0, porta_data_oe);
    end
  endtask : s_offset
  task automatic s_b_read;
    for (int n = 0; n < 6; n++) begin
      op_b(0, 0);
      chk("portb fifo read", 36'hA00000000 + ((n < 5) ? n : 4), portb_data_out);
      chk("portb oe on read", 36'h1, portb_data_oe);
    end
    chk("portb empty", 36'h0, portb_empty_n);
  endtask : s_b_read
  task automatic s_swap;
    logic [1:0] key;
    for (int k = 0; k < 4; k++) begin
      key = (k == 1) ? 2'h3 : (k == 2) ? 2'h2 : (k == 3) ? 2'h1 : 2'h0;
      @(posedge clock);
      {portb_swap_sel_hi, portb_swap_sel_lo} <= k[1:0];
      op_b(1, 36'h123456789);
      op_a(0, 0, 0);
      chk("swapped word", swp(36'h123456789, key), porta_data_out);
      chk("porta oe on read", 36'h1, porta_data_oe);
      op_a(1, 0, 36'h123456789);
      op_b(0, 0);
      chk("swapped read", swp(36'h123456789, key), portb_data_out);
    end
  endtask : s_swap
  task automatic s_mail;
    op_a(1, 1, 36'h5A5A5A5A5);
    chk("mail1 flag set", 36'h0, a_to_b_mail_flag_n);
    op_a(1, 1, 36'h111111111);
    @(posedge clock);
    {portb_size_sel_hi, portb_size_sel_lo} <= 2'h3;
    repeat (3) @(posedge clock);
    #1;
    chk("size applied", 36'h3, portb_size_applied);
    op_b(0, 0);
    chk("mail1 data", 36'h5A5A5A5A5, portb_data_out);
    chk("mail1 flag clear", 36'h1, a_to_b_mail_flag_n);
    @(posedge clock);
    portb_parity_gen_en <= 1;
    odd_even_sel <= 1;
    op_b(0, 0);
    chk("odd parity", par(36'h5A5A5A5A5, 1), portb_data_out);
    @(posedge clock);
    odd_even_sel <= 0;
    op_b(0, 0);
    chk("even parity", par(36'h5A5A5A5A5, 0), portb_data_out);
    op_b(1, 36'h0F0F0F0F0);
    chk("mail2 flag set", 36'h0, b_to_a_mail_flag_n);
    chk("no fifo write", 36'h0, porta_empty_n);
    op_a(0, 1, 0);
    chk("mail2 data", 36'h0F0F0F0F0, porta_data_out);
    chk("mail2 flag clear", 36'h1, b_to_a_mail_flag_n);
  endtask : s_mail
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
  initial begin
    s_offset();
    s_b_read();
    s_swap();
    s_mail();
    finish_test();
  end
endmodule : bdf_port_ctrl_tb_top
